// ---- core/dhp_pkg.sv ----
// Purpose: shared constants of the display host port
// Assumes: clk is the reference clock of the controller
// Notes: command codes, field positions, reset values
package dhp_pkg;
  // Command codes
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h01;
  localparam logic [7:0] CMD_GET_POWER = 8'h0A;
  localparam logic [7:0] CMD_GET_ADDR_MODE = 8'h0B;
  localparam logic [7:0] CMD_GET_PIX_FMT = 8'h0C;
  localparam logic [7:0] CMD_GET_DISP_MODE = 8'h0D;
  localparam logic [7:0] CMD_GET_SIG_MODE = 8'h0E;
  localparam logic [7:0] CMD_SLEEP_IN = 8'h10;
  localparam logic [7:0] CMD_SLEEP_OUT = 8'h11;
  localparam logic [7:0] CMD_PARTIAL = 8'h12;
  localparam logic [7:0] CMD_NORMAL = 8'h13;
  localparam logic [7:0] CMD_INVERT_OFF = 8'h20;
  localparam logic [7:0] CMD_INVERT_ON = 8'h21;
  localparam logic [7:0] CMD_GAMMA = 8'h26;
  localparam logic [7:0] CMD_DISP_OFF = 8'h28;
  localparam logic [7:0] CMD_DISP_ON = 8'h29;
  localparam logic [7:0] CMD_COLUMNS = 8'h2A;
  localparam logic [7:0] CMD_PAGES = 8'h2B;
  localparam logic [7:0] CMD_MEM_WRITE = 8'h2C;
  localparam logic [7:0] CMD_MEM_READ = 8'h2E;
  localparam logic [7:0] CMD_PART_AREA = 8'h30;
  localparam logic [7:0] CMD_SCROLL_AREA = 8'h33;
  localparam logic [7:0] CMD_TEAR_OFF = 8'h34;
  localparam logic [7:0] CMD_TEAR_ON = 8'h35;
  localparam logic [7:0] CMD_ADDR_MODE = 8'h36;
  // Bus pixel formats
  typedef enum logic [2:0] {
    FMT_8 = 3'h0,
    FMT_9 = 3'h1,
    FMT_565 = 3'h2,
    FMT_18 = 3'h3,
    FMT_24 = 3'h4
  } pix_fmt_t;
  // Read timing in reference clock periods, then FIFO depth and widths
  localparam int FIRST_READ_PERIODS = 5;
  localparam int FIFO_DEPTH = 8;
  localparam int COORD_W = 16;
  localparam int DATA_W = 24;
  // Status bit positions
  localparam int PM_DISP_BIT = 2;
  localparam int PM_NORMAL_BIT = 3;
  localparam int PM_AWAKE_BIT = 4;
  localparam int DM_INVERT_BIT = 5;
  localparam int SM_TEAR_BIT = 7;
  // Reset values
  localparam logic [7:0] GAMMA_RST = 8'h01;
  localparam logic [7:0] ADDR_MODE_RST = 8'h00;
  localparam logic [15:0] COL_END_RST = 16'h027F;
  localparam logic [15:0] PAGE_END_RST = 16'h01DF;
endpackage : dhp_pkg

// ---- core/pix_fifo_if.sv ----
// Purpose: carrier between the host port and its pixel FIFO
// Assumes: one clock for both sides
// Notes: fill side is the decoder, store side the FIFO
`timescale 1ns/1ns
`default_nettype none
interface pix_fifo_if #(parameter int W = 8);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport fill(output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
  modport store(input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
endinterface : pix_fifo_if
`default_nettype wire

// ---- core/pix_fifo.sv ----
// Purpose: small FIFO between host writes and frame memory
// Assumes: DEPTH is a power of two
// Notes: extra pointer bit tells full from empty
`timescale 1ns/1ns
`default_nettype none
module pix_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  pix_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);

  // Pointer arithmetic needs a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("pix_fifo DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wp_q;
  logic [AW:0] rp_q;
  wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  wire empty = (wp_q == rp_q);
  wire push = f.in_valid && !full;
  wire pop = f.out_ready && !empty;

  // Honest flags give back-pressure to the writer
  assign f.in_ready = !full;
  assign f.out_valid = !empty;
  assign f.out_data = mem_q[rp_q[AW-1:0]];

  // Storage has no reset; pointers guard it
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q[AW-1:0]] <= f.in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
endmodule : pix_fifo
`default_nettype wire

// ---- core/display_host_port.sv ----
// Purpose: parallel host port and command decoder
// Assumes: clk is the reference clock; pins are asynchronous
// Notes: frame memory sits outside, behind mem_* ports
`timescale 1ns/1ns
`default_nettype none
module display_host_port
  import dhp_pkg::*;
#(
  parameter int RD_DELAY = FIRST_READ_PERIODS,
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bus_i80,
  input wire logic cs_n,
  input wire logic strobe_n,
  input wire logic dir_rd,
  input wire logic register_data_select,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [2:0] pix_fmt,
  input wire logic first_general_pin_plain,
  input wire logic vertical_front_porch,
  output logic first_general_pin,
  output logic panel_on,
  output logic display_on,
  output logic partial_on,
  output logic invert_on,
  output logic [7:0] gamma_sel,
  output logic [7:0] address_mode,
  output logic [COORD_W-1:0] partial_start,
  output logic [COORD_W-1:0] partial_end,
  output logic [COORD_W-1:0] scroll_top,
  output logic [COORD_W-1:0] scroll_area,
  output logic [COORD_W-1:0] scroll_bottom,
  output logic tear_effect,
  output logic host_wait,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [COORD_W-1:0] mem_wr_col,
  output logic [COORD_W-1:0] mem_wr_page,
  output logic [DATA_W-1:0] mem_wr_data,
  output logic mem_rd_req,
  output logic [COORD_W-1:0] mem_rd_col,
  output logic [COORD_W-1:0] mem_rd_page,
  input wire logic mem_rd_valid,
  input wire logic [DATA_W-1:0] mem_rd_data
);
  localparam int FW = DATA_W + 2 * COORD_W;

  // Read delay counter is three bits wide
  if (RD_DELAY < 1 || RD_DELAY > 7) begin : g_bad_delay
    $error("RD_DELAY must lie in 1..7");
  end

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_PARAM = 5'h02,
    S_MWR = 5'h04,
    S_MRD = 5'h08,
    S_STAT = 5'h10
  } state_t;

  // Two-flop synchronisers on every host bus pin
  logic [DATA_W+4:0] meta_q;
  logic [DATA_W+4:0] sync_q;
  // Reset to idle pin levels, else release looks like the end of a write
  localparam logic [DATA_W+4:0] PINS_IDLE = {1'h0, 2'h3, 2'h0, {DATA_W{1'h0}}};
  wire [DATA_W+4:0] pins = {bus_i80, cs_n, strobe_n, dir_rd, register_data_select, data_in};
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q <= PINS_IDLE;
      sync_q <= PINS_IDLE;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  wire s_i80 = sync_q[DATA_W+4];
  wire s_sel = !sync_q[DATA_W+3];
  wire s_stb = sync_q[DATA_W+2];
  wire s_dir = sync_q[DATA_W+1];
  wire s_rs = sync_q[DATA_W];
  wire [DATA_W-1:0] s_data = sync_q[DATA_W-1:0];

  // Access phases; a 6800 access ends on select or strobe rise
  wire rd_now = s_i80 ? (s_sel && !s_dir) : (s_sel && !s_stb && s_dir);
  wire wr_now = s_i80 ? (s_sel && !s_stb) : (s_sel && !s_stb && !s_dir);
  wire act_now = rd_now || wr_now;

  logic act_q;
  logic isrd_q;
  logic rs_q;
  logic [DATA_W-1:0] dat_q;
  // Last sample while active is the latched word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      act_q <= 1'b0;
      isrd_q <= 1'b0;
      rs_q <= 1'b0;
      dat_q <= '0;
    end else begin
      act_q <= act_now;
      if (act_now) begin
        isrd_q <= rd_now;
        rs_q <= s_rs;
        dat_q <= s_data;
      end
    end
  end

  wire acc_end = act_q && !act_now;
  wire rd_end = acc_end && isrd_q;
  wire cmd_wr = acc_end && !isrd_q && !rs_q;
  wire prm_wr = acc_end && !isrd_q && rs_q;
  wire [7:0] code = dat_q[7:0];

  // Decoder state
  state_t st_q;
  logic [7:0] cmd_q;
  logic [2:0] pidx_q;
  logic [47:0] pbuf_q;
  logic [1:0] ph_q;
  logic [8:0] w0_q;
  logic [8:0] w1_q;
  logic [7:0] stat_q;
  logic [DATA_W-1:0] pix_rd_q;
  logic [COORD_W-1:0] col_q, page_q;
  logic [COORD_W-1:0] col_s_q, col_e_q, page_s_q, page_e_q;
  logic sleep_q, disp_q, part_q, inv_q, tear_q, gpio_q;

  pix_fmt_t fmt;
  assign fmt = pix_fmt_t'(pix_fmt);

  // Parameter bytes shift in, most significant first
  wire [47:0] pnext = {pbuf_q[39:0], code};
  wire one_byte = (cmd_q == CMD_GAMMA) || (cmd_q == CMD_ADDR_MODE);
  wire [2:0] plast = (cmd_q == CMD_SCROLL_AREA) ? 3'h5 : (one_byte ? 3'h0 : 3'h3);
  wire prm_last = (st_q == S_PARAM) && prm_wr && (pidx_q == plast);

  // Last cycle index per format; 8 and 9 bit buses split a pixel
  wire [1:0] phl = (fmt == FMT_8) ? 2'h2 : ((fmt == FMT_9) ? 2'h1 : 2'h0);
  wire wr_pix = (st_q == S_MWR) && prm_wr && (ph_q == phl);
  wire rd_pix = (st_q == S_MRD) && rd_end && (ph_q == phl);
  wire adv = wr_pix || rd_pix;

  // Window walk: column first, then page, wrap in the window
  wire col_wrap = (col_q == col_e_q);
  wire [COORD_W-1:0] col_nx = col_wrap ? col_s_q : col_q + 16'h0001;
  wire [COORD_W-1:0] pg_inc = (page_q == page_e_q) ? page_s_q : page_q + 16'h0001;
  wire [COORD_W-1:0] pg_nx = col_wrap ? pg_inc : page_q;

  // Incoming pixel widened to 8:8:8, red first on split buses
  logic [DATA_W-1:0] wpix;
  always_comb begin
    case (fmt)
      FMT_8: wpix = {w0_q[7:2], 2'h0, w1_q[7:2], 2'h0, dat_q[7:2], 2'h0};
      FMT_9: wpix = {w0_q[8:3], 2'h0, w0_q[2:0], dat_q[8:6], 2'h0, dat_q[5:0], 2'h0};
      FMT_565: wpix = {dat_q[15:11], 3'h0, dat_q[10:5], 2'h0, dat_q[4:0], 3'h0};
      FMT_18: wpix = {dat_q[17:12], 2'h0, dat_q[11:6], 2'h0, dat_q[5:0], 2'h0};
      default: wpix = dat_q;
    endcase
  end

  // Outgoing word for the present read phase
  wire [5:0] r6 = pix_rd_q[23:18];
  wire [5:0] g6 = pix_rd_q[15:10];
  wire [5:0] b6 = pix_rd_q[7:2];
  logic [DATA_W-1:0] rpix;
  always_comb begin
    case (fmt)
      FMT_8: begin
        case (ph_q)
          2'h0: rpix = {16'h0000, r6, 2'h0};
          2'h1: rpix = {16'h0000, g6, 2'h0};
          default: rpix = {16'h0000, b6, 2'h0};
        endcase
      end
      FMT_9: rpix = (ph_q == 2'h0) ? {15'h0000, r6, g6[5:3]} : {15'h0000, g6[2:0], b6};
      FMT_565: rpix = {8'h00, pix_rd_q[23:19], g6, pix_rd_q[7:3]};
      FMT_18: rpix = {6'h00, r6, g6, b6};
      default: rpix = pix_rd_q;
    endcase
  end

  wire [DATA_W-1:0] rd_word = (st_q == S_STAT) ? {16'h0000, stat_q} :
                              ((st_q == S_MRD) ? rpix : '0);

  // Status bytes for the query commands
  wire [7:0] pm_byte = (8'(disp_q) << PM_DISP_BIT) | (8'(!part_q) << PM_NORMAL_BIT)
                     | (8'(!sleep_q) << PM_AWAKE_BIT);
  wire [7:0] dm_byte = 8'(inv_q) << DM_INVERT_BIT;
  wire [7:0] sm_byte = 8'(tear_q) << SM_TEAR_BIT;

  // Command sequencer; a new command always aborts the old one
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      cmd_q <= CMD_NOP;
      pidx_q <= 3'h0;
      pbuf_q <= '0;
      ph_q <= 2'h0;
      w0_q <= '0;
      w1_q <= '0;
      stat_q <= 8'h00;
    end else if (cmd_wr) begin
      cmd_q <= code;
      pidx_q <= 3'h0;
      ph_q <= 2'h0;
      case (code)
        CMD_GET_POWER: stat_q <= pm_byte;
        CMD_GET_ADDR_MODE: stat_q <= address_mode;
        CMD_GET_PIX_FMT: stat_q <= {5'h00, pix_fmt};
        CMD_GET_DISP_MODE: stat_q <= dm_byte;
        CMD_GET_SIG_MODE: stat_q <= sm_byte;
        default: stat_q <= stat_q;
      endcase
      case (code)
        CMD_GET_POWER, CMD_GET_ADDR_MODE, CMD_GET_PIX_FMT,
        CMD_GET_DISP_MODE, CMD_GET_SIG_MODE: st_q <= S_STAT;
        CMD_GAMMA, CMD_COLUMNS, CMD_PAGES, CMD_PART_AREA,
        CMD_SCROLL_AREA, CMD_ADDR_MODE: st_q <= S_PARAM;
        CMD_MEM_WRITE: st_q <= S_MWR;
        CMD_MEM_READ: st_q <= S_MRD;
        default: st_q <= S_IDLE;
      endcase
    end else begin
      if (prm_wr && st_q == S_PARAM) begin
        pbuf_q <= pnext;
        pidx_q <= pidx_q + 3'h1;
        if (prm_last) st_q <= S_IDLE;
      end
      if ((st_q == S_MWR && prm_wr) || (st_q == S_MRD && rd_end)) begin
        ph_q <= (ph_q == phl) ? 2'h0 : ph_q + 2'h1;
      end
      if (st_q == S_MWR && prm_wr && ph_q == 2'h0) w0_q <= dat_q[8:0];
      if (st_q == S_MWR && prm_wr && ph_q == 2'h1) w1_q <= dat_q[8:0];
    end
  end

  // Display state; soft reset restores power-up values
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_q <= 1'b1;
      gpio_q <= 1'b0;
      disp_q <= 1'b0;
      part_q <= 1'b0;
      inv_q <= 1'b0;
      tear_q <= 1'b0;
      gamma_sel <= GAMMA_RST;
      address_mode <= ADDR_MODE_RST;
    end else if (cmd_wr && code == CMD_SOFT_RESET) begin
      sleep_q <= 1'b1;
      gpio_q <= 1'b0;
      disp_q <= 1'b0;
      part_q <= 1'b0;
      inv_q <= 1'b0;
      tear_q <= 1'b0;
      gamma_sel <= GAMMA_RST;
      address_mode <= ADDR_MODE_RST;
    end else if (cmd_wr) begin
      // Sleep codes only act while the pin serves power control
      if (code == CMD_SLEEP_IN && !first_general_pin_plain) begin
        sleep_q <= 1'b1;
        gpio_q <= 1'b0;
      end
      if (code == CMD_SLEEP_OUT && !first_general_pin_plain) begin
        sleep_q <= 1'b0;
        gpio_q <= 1'b1;
      end
      if (code == CMD_PARTIAL) part_q <= 1'b1;
      if (code == CMD_NORMAL) part_q <= 1'b0;
      if (code == CMD_INVERT_ON) inv_q <= 1'b1;
      if (code == CMD_INVERT_OFF) inv_q <= 1'b0;
      if (code == CMD_DISP_OFF) disp_q <= 1'b0;
      if (code == CMD_DISP_ON) disp_q <= 1'b1;
      if (code == CMD_TEAR_ON) tear_q <= 1'b1;
      if (code == CMD_TEAR_OFF) tear_q <= 1'b0;
    end else if (prm_last) begin
      if (cmd_q == CMD_GAMMA) gamma_sel <= pnext[7:0];
      if (cmd_q == CMD_ADDR_MODE) address_mode <= pnext[7:0];
    end
  end

  // Window and region bounds, four or six bytes each
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      col_s_q <= '0;
      col_e_q <= COL_END_RST;
      page_s_q <= '0;
      page_e_q <= PAGE_END_RST;
      partial_start <= '0;
      partial_end <= PAGE_END_RST;
      scroll_top <= '0;
      scroll_area <= '0;
      scroll_bottom <= '0;
    end else if (prm_last) begin
      if (cmd_q == CMD_COLUMNS) begin
        col_s_q <= pnext[31:16];
        col_e_q <= pnext[15:0];
      end
      if (cmd_q == CMD_PAGES) begin
        page_s_q <= pnext[31:16];
        page_e_q <= pnext[15:0];
      end
      if (cmd_q == CMD_PART_AREA) begin
        partial_start <= pnext[31:16];
        partial_end <= pnext[15:0];
      end
      if (cmd_q == CMD_SCROLL_AREA) begin
        scroll_top <= pnext[47:32];
        scroll_area <= pnext[31:16];
        scroll_bottom <= pnext[15:0];
      end
    end
  end

  // Memory pointer: load window start, advance per pixel
  wire start_mem = cmd_wr && (code == CMD_MEM_WRITE || code == CMD_MEM_READ);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      col_q <= '0;
      page_q <= '0;
    end else if (start_mem) begin
      col_q <= col_s_q;
      page_q <= page_s_q;
    end else if (adv) begin
      col_q <= col_nx;
      page_q <= pg_nx;
    end
  end

  // Fetch on read start and after each pixel is sent out
  logic req_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      req_q <= 1'b0;
      pix_rd_q <= '0;
    end else begin
      req_q <= (cmd_wr && code == CMD_MEM_READ) || rd_pix;
      if (mem_rd_valid) pix_rd_q <= mem_rd_data;
    end
  end
  assign mem_rd_req = req_q;
  assign mem_rd_col = col_q;
  assign mem_rd_page = page_q;

  // Read drive waits out the first read delay
  logic [2:0] rcnt_q;
  logic oe_q;
  logic [DATA_W-1:0] dout_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rcnt_q <= 3'h0;
      oe_q <= 1'b0;
      dout_q <= '0;
    end else begin
      rcnt_q <= !rd_now ? 3'h0 : ((rcnt_q == 3'h7) ? rcnt_q : rcnt_q + 3'h1);
      oe_q <= rd_now && (rcnt_q >= 3'(RD_DELAY - 1));
      dout_q <= rd_word;
    end
  end
  assign data_out = dout_q;
  assign data_oe = oe_q;

  // Pixel writes queue up for frame memory
  pix_fifo_if #(.W(FW)) wq ();
  assign wq.in_valid = wr_pix;
  assign wq.in_data = {page_q, col_q, wpix};
  assign wq.out_ready = mem_wr_ready;
  assign mem_wr_valid = wq.out_valid;
  assign mem_wr_page = wq.out_data[FW-1:DATA_W+COORD_W];
  assign mem_wr_col = wq.out_data[DATA_W+COORD_W-1:DATA_W];
  assign mem_wr_data = wq.out_data[DATA_W-1:0];
  // Host has no wait line of its own; it must poll this before writing
  assign host_wait = !wq.in_ready;

  pix_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .f(wq.store)
  );

  // Tear output follows the porch level, one cycle later, while enabled
  logic tear_out_q;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) tear_out_q <= 1'b0;
    else tear_out_q <= tear_q && vertical_front_porch;
  end
  assign tear_effect = tear_out_q;

  assign first_general_pin = gpio_q;
  assign panel_on = !sleep_q;
  assign display_on = disp_q;
  assign partial_on = part_q;
  assign invert_on = inv_q;
endmodule : display_host_port
`default_nettype wire

// ---- test/dhp_monitor.sv ----
// Purpose: pin-level assertions on the display host port
// Assumes: pads pass a two-flop sync before use
// Notes: bound to every display_host_port
`timescale 1ns/1ns
`default_nettype none
module dhp_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cs_n,
  input wire logic first_general_pin_plain,
  input wire logic vertical_front_porch,
  input wire logic first_general_pin,
  input wire logic panel_on,
  input wire logic display_on,
  input wire logic [7:0] gamma_sel,
  input wire logic tear_effect,
  input wire logic data_oe,
  input wire logic host_wait,
  input wire logic mem_wr_valid,
  input wire logic mem_rd_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Unselected long enough for any access to have ended
  sequence s_gone;
    cs_n [*8];
  endsequence
  tear_pulse_a: assert property (tear_effect |-> $past(vertical_front_porch))
    else $error("tear pulse without porch");
  pin_track_a: assert property (first_general_pin == panel_on)
    else $error("first pin and panel differ");
  sleep_lock_a: assert property ($past(first_general_pin_plain) |-> !$rose(panel_on))
    else $error("wake while pin is plain");
  read_delay_a: assert property ($rose(data_oe) |-> !$past(cs_n, 6))
    else $error("read data too early");
  oe_release_a: assert property (s_gone |-> !data_oe)
    else $error("pads driven while unselected");
  deselect_a: assert property (s_gone |=> $stable(gamma_sel) && $stable(display_on))
    else $error("state changed while unselected");
  rd_pulse_a: assert property (mem_rd_req |=> !mem_rd_req)
    else $error("read request too long");
  full_valid_a: assert property (host_wait |-> mem_wr_valid)
    else $error("full buffer shows no data");
endmodule : dhp_monitor
bind display_host_port dhp_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n),
  .first_general_pin_plain(first_general_pin_plain), .vertical_front_porch(vertical_front_porch),
  .first_general_pin(first_general_pin), .panel_on(panel_on), .display_on(display_on),
  .gamma_sel(gamma_sel), .tear_effect(tear_effect), .data_oe(data_oe),
  .host_wait(host_wait), .mem_wr_valid(mem_wr_valid), .mem_rd_req(mem_rd_req));
`default_nettype wire

// ---- test/host_model.sv ----
// Purpose: host processor driving the parallel pads
// Assumes: accesses start at a falling clock edge
// Notes: long holds let the pad sync settle
`timescale 1ns/1ns
`default_nettype none
module host_model (
  input wire logic clk,
  input wire logic bus_i80,
  output logic cs_n,
  output logic strobe_n,
  output logic dir_rd,
  output logic rsel,
  output logic [23:0] data_in,
  input wire logic [23:0] data_out,
  input wire logic data_oe
);
  logic by_cs = 1'b0; // 6800 timed by select, not strobe
  // Idle pads
  initial begin
    cs_n = 1'b1;
    strobe_n = 1'b1;
    dir_rd = 1'b1;
    rsel = 1'b0;
    data_in = 24'h000000;
  end
  // One access: assert, hold, wait for read data, release
  task automatic acc(input logic r, input logic rd, input logic [23:0] d,
                     output logic [23:0] q);
    int n;
    n = 0;
    @(negedge clk);
    cs_n = 1'b0;
    rsel = r;
    data_in = d;
    dir_rd = bus_i80 ? !rd : rd;
    strobe_n = bus_i80 && rd;
    repeat (3) @(negedge clk);
    while (rd && data_oe !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    q = (n < 40) ? data_out : 'x;
    cs_n = by_cs || bus_i80;
    strobe_n = !(by_cs && !bus_i80);
    dir_rd = bus_i80;
    data_in = ~d; // Released bus must not show a stale value
    repeat (4) @(negedge clk);
  endtask : acc
endmodule : host_model
`default_nettype wire

// ---- test/tb_display_host_port.sv ----
// Purpose: self-checking bench of display_host_port
// Assumes: host_model drives the pads; bench plays frame memory
// Notes: pixels checked in the 24, 8 and 565 bus formats
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module tb_display_host_port
  import dhp_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, bus_i80 = 1'b0, first_general_pin_plain = 1'b0, porch = 1'b0;
  logic mem_wr_ready = 1'b0, mem_rd_valid = 1'b0, drain = 1'b0;
  logic cs_n, strobe_n, dir_rd, rsel, data_oe, first_general_pin, panel_on, display_on;
  logic partial_on, invert_on, tear_effect, host_wait, mem_wr_valid, mem_rd_req;
  logic [2:0] pix_fmt = FMT_24;
  logic [7:0] gamma_sel, address_mode;
  logic [15:0] partial_start, partial_end, scroll_top, scroll_area, scroll_bottom;
  logic [15:0] mem_wr_col, mem_wr_page, mem_rd_col, mem_rd_page;
  logic [23:0] data_in, data_out, mem_wr_data, mem_rd_data = 24'h000000, q;
  logic [39:0] wq[$];
  int error_cnt = 0, num_checks = 0, tear_n = 0;
  always #50 clk = ~clk;
  display_host_port u_dut (.clk(clk), .sys_rst(sys_rst), .bus_i80(bus_i80), .cs_n(cs_n),
    .strobe_n(strobe_n), .dir_rd(dir_rd), .register_data_select(rsel), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .pix_fmt(pix_fmt), .first_general_pin_plain(first_general_pin_plain),
    .vertical_front_porch(porch), .first_general_pin(first_general_pin), .panel_on(panel_on),
    .display_on(display_on), .partial_on(partial_on), .invert_on(invert_on),
    .gamma_sel(gamma_sel), .address_mode(address_mode), .partial_start(partial_start),
    .partial_end(partial_end), .scroll_top(scroll_top), .scroll_area(scroll_area),
    .scroll_bottom(scroll_bottom), .tear_effect(tear_effect), .host_wait(host_wait),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready), .mem_wr_col(mem_wr_col),
    .mem_wr_page(mem_wr_page), .mem_wr_data(mem_wr_data), .mem_rd_req(mem_rd_req),
    .mem_rd_col(mem_rd_col), .mem_rd_page(mem_rd_page), .mem_rd_valid(mem_rd_valid),
    .mem_rd_data(mem_rd_data));
  host_model host (.clk(clk), .bus_i80(bus_i80), .cs_n(cs_n), .strobe_n(strobe_n),
    .dir_rd(dir_rd), .rsel(rsel), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  // Frame memory stand-in, looking at settled outputs on the falling edge;
  // ready follows drain from the same look, so every logged word is a real pop
  always @(negedge clk) begin
    if (mem_wr_valid === 1'b1 && drain)
      wq.push_back({mem_wr_col[7:0], mem_wr_page[7:0], mem_wr_data});
    mem_wr_ready <= drain;
    if (tear_effect === 1'b1) tear_n++;
    mem_rd_valid <= mem_rd_req;
    mem_rd_data <= {8'hC3, mem_rd_col[7:0], mem_rd_page[7:0]};
  end
  task automatic cmd(input logic [7:0] c);
    host.acc(1'b0, 1'b0, {16'h0000, c}, q);
  endtask : cmd
  task automatic put(input logic [23:0] d);
    host.acc(1'b1, 1'b0, d, q);
  endtask : put
  task automatic get();
    host.acc(1'b1, 1'b1, 24'h000000, q);
  endtask : get
  task automatic cmdp(input logic [7:0] c, input logic [7:0] p[$]);
    cmd(c);
    foreach (p[i]) put({16'h0000, p[i]});
  endtask : cmdp
  // Wake, then sleep refused while the pin is plain
  task automatic t_power();
    first_general_pin_plain = 1'b1;
    cmd(CMD_SLEEP_OUT);
    `CHK("plain_out", 1'b0, panel_on)
    first_general_pin_plain = 1'b0;
    cmd(CMD_SLEEP_OUT);
    `CHK("awake", 1'b1, first_general_pin)
    cmd(CMD_GET_POWER);
    get();
    `CHK("pwr", 1'b1, q[PM_AWAKE_BIT])
    first_general_pin_plain = 1'b1;
    cmd(CMD_SLEEP_IN);
    `CHK("plain", 1'b1, panel_on)
    first_general_pin_plain = 1'b0;
    cmd(CMD_SLEEP_IN);
    `CHK("sleep", 1'b0, first_general_pin)
  endtask : t_power
  task automatic t_soft();
    cmdp(CMD_GAMMA, '{8'h08});
    `CHK("gamma", 8'h08, gamma_sel)
    cmd(CMD_NOP);
    `CHK("nop", 8'h08, gamma_sel)
    cmd(CMD_SOFT_RESET);
    `CHK("soft", GAMMA_RST, gamma_sel)
  endtask : t_soft
  task automatic t_params();
    cmdp(CMD_ADDR_MODE, '{8'hA5});
    cmd(CMD_GET_ADDR_MODE);
    get();
    `CHK("amode", 8'hA5, q[7:0])
    `CHK("amode_port", 8'hA5, address_mode)
    cmd(CMD_GET_PIX_FMT);
    get();
    `CHK("fmt", {5'h00, pix_fmt}, q[7:0])
    cmdp(CMD_PART_AREA, '{8'h00, 8'h10, 8'h01, 8'h20});
    `CHK("part", 32'h00100120, {partial_start, partial_end})
    cmdp(CMD_SCROLL_AREA, '{8'h00, 8'h05, 8'h01, 8'hC0, 8'h00, 8'h1B});
    `CHK("scroll", 48'h000501C0001B, {scroll_top, scroll_area, scroll_bottom})
  endtask : t_params
  // Each mode off, then on; tear pulses counted per porch pulse
  task automatic t_modes();
    int n0;
    for (int v = 0; v < 2; v++) begin
      cmd(v ? CMD_DISP_ON : CMD_DISP_OFF);
      `CHK("disp", v[0], display_on)
      cmd(v ? CMD_PARTIAL : CMD_NORMAL);
      cmd(CMD_GET_POWER);
      get();
      `CHK("partial", {v[0], !v[0]}, {partial_on, q[PM_NORMAL_BIT]})
      cmd(v ? CMD_INVERT_ON : CMD_INVERT_OFF);
      cmd(CMD_GET_DISP_MODE);
      get();
      `CHK("inv", {v[0], v[0]}, {invert_on, q[DM_INVERT_BIT]})
      cmd(v ? CMD_TEAR_ON : CMD_TEAR_OFF);
      n0 = tear_n;
      porch = 1'b1;
      @(negedge clk) porch = 1'b0;
      repeat (3) @(negedge clk);
      `CHK("tear", v, tear_n - n0)
    end
  endtask : t_modes
  // 2 x 2 window filled twice with memory stalled, then drained
  task automatic t_write();
    cmdp(CMD_COLUMNS, '{8'h00, 8'h01, 8'h00, 8'h02});
    cmdp(CMD_PAGES, '{8'h00, 8'h03, 8'h00, 8'h04});
    cmd(CMD_MEM_WRITE);
    for (int i = 0; i < FIFO_DEPTH; i++) put(24'h102030 + 24'(i));
    `CHK("full", 1'b1, host_wait)
    drain = 1'b1;
    repeat (FIFO_DEPTH + 4) @(negedge clk);
    `CHK("count", FIFO_DEPTH, wq.size())
    for (int i = 0; i < FIFO_DEPTH; i++)
      `CHK("pix", {8'(1 + i % 2), 8'(3 + i / 2 % 2), 24'h102030 + 24'(i)}, wq[i])
  endtask : t_write
  // Three-cycle 8-bit pixel, then one 565 pixel, both widened to 8:8:8
  task automatic t_fmt();
    pix_fmt = FMT_8;
    cmd(CMD_MEM_WRITE);
    put(24'h0000FC);
    put(24'h000084);
    put(24'h000004);
    pix_fmt = FMT_565;
    put(24'h00F81F);
    repeat (4) @(negedge clk);
    `CHK("p8", {8'h01, 8'h03, 24'hFC8404}, wq[FIFO_DEPTH])
    `CHK("p565", {8'h02, 8'h03, 24'hF800F8}, wq[FIFO_DEPTH + 1])
    pix_fmt = FMT_24;
  endtask : t_fmt
  task automatic t_read();
    cmd(CMD_MEM_READ);
    for (int i = 0; i < 3; i++) begin
      get();
      `CHK("rd", {8'hC3, 8'(1 + i % 2), 8'(3 + i / 2)}, q)
    end
  endtask : t_read
  task automatic t_i80();
    bus_i80 = 1'b1;
    repeat (4) @(negedge clk);
    cmd(CMD_DISP_OFF);
    `CHK("i80", 1'b0, display_on)
    cmd(CMD_GET_POWER);
    get();
    `CHK("i80rd", 1'b0, q[PM_DISP_BIT])
  endtask : t_i80
  task automatic stop_test();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // Main sequence; 6800 strobe timing first, then select timing
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    t_power();
    host.by_cs = 1'b1;
    t_soft();
    t_params();
    t_modes();
    t_write();
    t_fmt();
    t_read();
    t_i80();
    stop_test();
  end
  // Watchdog, about thirty times the expected run
  initial begin
    #2000000;
    error_cnt++;
    stop_test();
  end
endmodule : tb_display_host_port
`default_nettype wire
